// ==== design/kbiu_pkg.sv ====
/*
 * Package for the keyboard interrupt unit: register offsets, field
 * positions, reset values and the bus answer codes.
 * Assumes an AXI4-Lite master with 32-bit data and 8-bit register words.
 */
// Operation
// - Eight pins, own enables, one request
// - Enabled pin turns on its pull-up
// - Latch when pin falls, all were high
// - Edge mode: no latch if other low
// - Level mode: request held while pin low
// - Sensitivity bit, 1 level, reset 0
// - Level mode clears after ack and high
// - Edge mode: acknowledge clears at once
// - Vector fetch acts as acknowledge
// - Write-only acknowledge bit reads 0
// - Later falling edge latches fresh request
// - Mask bit blocks request, reset 0
// - Pending flag ignores mask, reset 0
// - Reset clears request even pin low
// - Enable forces pin to input
// - Enable register, one bit per pin
// - Status upper four bits read zero
// - Break blocks written ack unless clear enabled; vector fetch still clears
// - Active in wait, unmasked request wakes
package kbiu_pkg;
    localparam int          KBIU_PINS        = 8;
    localparam logic [3:0]  KBIU_OFS_SC      = 4'h0;
    localparam logic [3:0]  KBIU_OFS_EN      = 4'h4;
    localparam int          KBIU_BIT_SENS    = 0;
    localparam int          KBIU_BIT_MASK    = 1;
    localparam int          KBIU_BIT_ACK     = 2;
    localparam int          KBIU_BIT_PEND    = 3;
    localparam logic [7:0]  KBIU_RST_EN      = 8'h00;
    localparam logic        KBIU_RST_BIT     = 1'b0;
    localparam logic [1:0]  KBIU_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  KBIU_RESP_SLVERR = 2'h2;
endpackage

// ==== design/kbiu_pin_if.sv ====
/*
 * Interface carrying the synchronised keyboard pin levels between the
 * synchroniser and the unit's core logic.
 * Assumes both ends run on the same bus clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface kbiu_pin_if;
    logic [7:0] level;
    modport src (output level);
    modport dst (input level);
endinterface
`default_nettype wire

// ==== design/kbiu_sync.sv ====
/*
 * Two-stage synchroniser for the eight keyboard pins.
 * Assumes pins are asynchronous to CLK; first stage feeds only the second.
 */
`timescale 1ns/100ps
`default_nettype none
module kbiu_sync (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    input  wire logic [7:0] pin_in,
    kbiu_pin_if.src     pins
);
    logic [7:0] meta_reg;
    logic [7:0] sync_reg;

    // Reset to high so idle pulled-up keys show no edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 8'hff;
            sync_reg <= 8'hff;
        end else if (ce) begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pins.level = sync_reg;
endmodule
`default_nettype wire

// ==== design/kbiu_top.sv ====
/*
 * Keyboard interrupt unit: eight enabled pins, one shared request, pending
 * flag, acknowledge, mask, sensitivity select and AXI4-Lite registers.
 * Assumes CLK at 50 MHz, a vector-fetch pulse and break inputs from the
 * system integration unit, and port logic that uses the pull-up and
 * input-force outputs.
 */
`timescale 1ns/100ps
`default_nettype none
module kbiu_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic [7:0]  PORT_A_PINS,
    input  wire logic        VECTOR_FETCH,
    input  wire logic        BREAK_STATE,
    input  wire logic        BREAK_CLEAR_ENABLE,
    input  wire logic [3:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [3:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [7:0]       PULLUP_EN,
    output logic [7:0]       FORCE_INPUT,
    output logic             KEY_IRQ,
    output logic             WAKE_REQ
);
    kbiu_pin_if pins ();

    kbiu_sync u_sync (
        .clk    (CLK),
        .rst_n  (RST_N),
        .ce     (CE),
        .pin_in (PORT_A_PINS),
        .pins   (pins)
    );

    logic [7:0] key_pin_enables_reg;
    logic       key_sensitivity_select_reg;
    logic       key_request_mask_reg;
    logic       req_reg;
    logic       all_high_reg;
    logic       ack_seen_reg;
    logic       aw_have_reg;
    logic       w_have_reg;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // Full-word decode shared by read and write sides
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction

    // Write path: address and data taken in any order, answer after both
    logic       wr_go;
    logic       wr_sc;
    logic       wr_en;
    logic       wr_lane0;
    logic       ack_write;
    logic       ack_allowed;
    logic       vf_ack;
    logic       any_ack;
    assign wr_go     = aw_have_reg && w_have_reg && !BVALID;
    assign wr_lane0  = w_strb_reg[0];
    assign wr_sc     = wr_go && wr_lane0 && hit(aw_addr_reg,
                                                kbiu_pkg::KBIU_OFS_SC);
    assign wr_en     = wr_go && wr_lane0 && hit(aw_addr_reg,
                                                kbiu_pkg::KBIU_OFS_EN);
    assign ack_write = wr_sc && w_data_reg[kbiu_pkg::KBIU_BIT_ACK];
    assign ack_allowed = !BREAK_STATE || BREAK_CLEAR_ENABLE;
    assign vf_ack    = VECTOR_FETCH && KEY_IRQ;
    assign any_ack   = vf_ack || (ack_write && ack_allowed);

    // Pin view: only enabled pins take part
    logic       any_low;
    logic       fall;
    logic       req_next;
    logic       ack_seen_next;
    assign any_low  = |(key_pin_enables_reg & ~pins.level);
    assign fall     = any_low && all_high_reg;

    // Request latch; a fresh edge wins over a same-cycle acknowledge
    always_comb begin
        req_next      = req_reg;
        ack_seen_next = ack_seen_reg;
        if (key_sensitivity_select_reg) begin
            if (any_ack) begin
                ack_seen_next = 1'b1;
            end
            if (ack_seen_next && !any_low) begin
                req_next      = 1'b0;
                ack_seen_next = 1'b0;
            end
            if (any_low && !ack_seen_next) begin
                req_next = 1'b1;
            end
        end else begin
            ack_seen_next = 1'b0;
            if (any_ack) begin
                req_next = 1'b0;
            end
        end
        if (fall) begin
            req_next      = 1'b1;
            ack_seen_next = key_sensitivity_select_reg ? 1'b0 : 1'b0;
        end
    end

    // Latch state; reset drops it even with a pin held low
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            req_reg      <= kbiu_pkg::KBIU_RST_BIT;
            ack_seen_reg <= kbiu_pkg::KBIU_RST_BIT;
            all_high_reg <= 1'b1;
        end else if (CE) begin
            req_reg      <= req_next;
            ack_seen_reg <= ack_seen_next;
            all_high_reg <= !any_low;
        end
    end

    // Control registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            key_pin_enables_reg        <= kbiu_pkg::KBIU_RST_EN;
            key_sensitivity_select_reg <= kbiu_pkg::KBIU_RST_BIT;
            key_request_mask_reg       <= kbiu_pkg::KBIU_RST_BIT;
        end else if (CE) begin
            if (wr_en) begin
                key_pin_enables_reg <= w_data_reg[7:0];
            end
            if (wr_sc) begin
                key_sensitivity_select_reg <=
                    w_data_reg[kbiu_pkg::KBIU_BIT_SENS];
                key_request_mask_reg <=
                    w_data_reg[kbiu_pkg::KBIU_BIT_MASK];
            end
        end
    end

    // Pin-side and CPU-side outputs, all registered
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PULLUP_EN   <= 8'h00;
            FORCE_INPUT <= 8'h00;
            KEY_IRQ     <= 1'b0;
            WAKE_REQ    <= 1'b0;
        end else if (CE) begin
            PULLUP_EN   <= key_pin_enables_reg;
            FORCE_INPUT <= key_pin_enables_reg;
            KEY_IRQ     <= req_next && !key_request_mask_reg;
            WAKE_REQ    <= req_next && !key_request_mask_reg;
        end
    end

    // Write channel capture and response
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            AWREADY     <= 1'b1;
            WREADY      <= 1'b1;
            BVALID      <= 1'b0;
            BRESP       <= kbiu_pkg::KBIU_RESP_OKAY;
        end else if (CE) begin
            if (AWVALID && AWREADY) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= AWADDR;
                AWREADY     <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_have_reg <= 1'b1;
                w_data_reg <= WDATA;
                w_strb_reg <= WSTRB;
                WREADY     <= 1'b0;
            end
            if (wr_go) begin
                BVALID      <= 1'b1;
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                BRESP <= (hit(aw_addr_reg, kbiu_pkg::KBIU_OFS_SC) ||
                          hit(aw_addr_reg, kbiu_pkg::KBIU_OFS_EN))
                         ? kbiu_pkg::KBIU_RESP_OKAY
                         : kbiu_pkg::KBIU_RESP_SLVERR;
            end
            if (BVALID && BREADY) begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end

    // Read data: pending flag live, acknowledge and top bits zero
    logic [7:0] sc_view;
    logic       rd_sc;
    logic       rd_en;
    logic       rd_was_sc_reg;
    assign sc_view = {4'h0, req_reg, 1'b0, key_request_mask_reg,
                      key_sensitivity_select_reg};
    assign rd_sc   = hit(ARADDR, kbiu_pkg::KBIU_OFS_SC);
    assign rd_en   = hit(ARADDR, kbiu_pkg::KBIU_OFS_EN);

    // Read channel: one answer the cycle after the address is taken
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= kbiu_pkg::KBIU_RESP_OKAY;
            rd_was_sc_reg <= 1'b0;
        end else if (CE) begin
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
                rd_was_sc_reg <= rd_sc; // Lets checks tell status reads apart
                RVALID  <= 1'b1;
                RDATA   <= rd_sc ? {24'h000000, sc_view}
                         : rd_en ? {24'h000000, key_pin_enables_reg}
                         : 32'h0000_0000;
                RRESP   <= (rd_sc || rd_en) ? kbiu_pkg::KBIU_RESP_OKAY
                                            : kbiu_pkg::KBIU_RESP_SLVERR;
            end else if (RVALID && RREADY) begin
                RVALID  <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end

    // Checks on the latch and outputs
    mask_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && $past(CE) && key_request_mask_reg && $past(key_request_mask_reg)
        |-> !KEY_IRQ) else $error("request passed the mask");
    edge_latch_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && fall |=> req_reg) else $error("falling edge not latched");
    edge_ack_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && !key_sensitivity_select_reg && any_ack && !fall |=> !req_reg)
        else $error("edge mode ack did not clear");
    level_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && key_sensitivity_select_reg && req_reg && any_low |=> req_reg)
        else $error("level request dropped while pin low");
    edge_block_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && !key_sensitivity_select_reg && !req_reg && !all_high_reg
        && !fall |=> !req_reg) else $error("edge latched while pin low");
    break_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && BREAK_STATE && !BREAK_CLEAR_ENABLE && !vf_ack && req_reg
        && !ack_seen_reg
        |=> req_reg) else $error("ack cleared latch in break");
    ack_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
        RVALID && rd_was_sc_reg
        |-> !RDATA[kbiu_pkg::KBIU_BIT_ACK] && RDATA[7:4] == 4'h0)
        else $error("ack or upper bits read non-zero");
    pullup_follow_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE |=> PULLUP_EN == $past(key_pin_enables_reg))
        else $error("pull-up does not follow enable");
    wake_a: assert property (@(posedge CLK) disable iff (!RST_N)
        WAKE_REQ == KEY_IRQ) else $error("wake differs from request");
    edge_cov: cover property (@(posedge CLK) disable iff (!RST_N)
        fall && !key_sensitivity_select_reg);
    level_cov: cover property (@(posedge CLK) disable iff (!RST_N)
        key_sensitivity_select_reg && ack_seen_reg && any_low);
    break_cov: cover property (@(posedge CLK) disable iff (!RST_N)
        ack_write && BREAK_STATE);
    vec_ack_cov: cover property (@(posedge CLK) disable iff (!RST_N)
        vf_ack);
    mask_cov: cover property (@(posedge CLK) disable iff (!RST_N)
        req_reg && key_request_mask_reg);

    // Level mode: set while low, cleared once ack and release both seen; then fresh edge over ack and edge-mode break clear
    level_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && key_sensitivity_select_reg && any_low && !ack_seen_reg
        && !any_ack |=> req_reg)
        else $error("level request not set while pin low");
    level_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && key_sensitivity_select_reg && ack_seen_reg && !any_low
        |=> !req_reg)
        else $error("level request kept after ack and release");
    fresh_edge_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && fall && any_ack |=> req_reg)
        else $error("edge lost to same-cycle ack");
    break_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && BREAK_STATE && BREAK_CLEAR_ENABLE && ack_write
        && !key_sensitivity_select_reg && !fall |=> !req_reg)
        else $error("enabled break ack did not clear");

    // Register and pin-side outputs
    en_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && wr_en |=> key_pin_enables_reg == $past(w_data_reg[7:0]))
        else $error("enable write not stored");
    force_follow_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE |=> FORCE_INPUT == $past(key_pin_enables_reg))
        else $error("input force does not follow enable");
    pend_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && ARVALID && ARREADY && rd_sc
        |=> RDATA[kbiu_pkg::KBIU_BIT_PEND] == $past(req_reg))
        else $error("pending flag read wrong");
    upper_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
        RVALID |-> RDATA[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    // Bus channels: answers stand, readies stay low while one is open
    bvalid_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    ready_block_a: assert property (@(posedge CLK) disable iff (!RST_N)
        BVALID |-> !AWREADY && !WREADY)
        else $error("write ready high with response open");
    ar_block_a: assert property (@(posedge CLK) disable iff (!RST_N)
        RVALID |-> !ARREADY)
        else $error("read ready high with data open");
    slverr_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && wr_go && !hit(aw_addr_reg, kbiu_pkg::KBIU_OFS_SC)
        && !hit(aw_addr_reg, kbiu_pkg::KBIU_OFS_EN)
        |=> BRESP == kbiu_pkg::KBIU_RESP_SLVERR)
        else $error("unmapped write not refused");

    // Clock enable low holds every register where it is
    freeze_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !CE |=> $stable(req_reg) && $stable(key_pin_enables_reg)
        && $stable(KEY_IRQ) && $stable(BVALID) && $stable(RVALID))
        else $error("state moved with clock enable low");
endmodule
`default_nettype wire

// ==== tb/kbiu_keys.sv ====
/*
 * Model of the keys on the eight port pins.
 * Assumes a pressed key pulls its pin low; a released pin is high only
 * while its pull-up is on, otherwise it floats.
 */
`timescale 1ns/100ps
`default_nettype none
module kbiu_keys (
    input  wire logic       clk,
    input  wire logic [7:0] press,
    input  wire logic [7:0] pull_on,
    output logic      [7:0] pins
);
    logic [7:0] wobble = 8'h5a;

    // Floating pins toggle so no stale level hides a fault
    always @(posedge clk) begin
        wobble <= ~wobble;
    end

    // Key wins over pull-up; pull-up wins over float
    assign pins = ~press & (pull_on | wobble);
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the keyboard interrupt unit.
 * Assumes the key model on the pins and an AXI4-Lite master in tasks.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        vf = 1'b0;
    logic        brk = 1'b0;
    logic        bce = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [3:0]  wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, wake;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, got;
    logic [7:0]  pins, pull, frc;
    logic [7:0]  press = 8'h00;
    logic [31:0] rnd = 32'h61d85a29;
    int          k, k2;
    int          error_cnt = 0;
    int          comparisons = 0;

    // Free-running 50 MHz clock
    always #10 clk = ~clk;

    kbiu_top uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .PORT_A_PINS(pins),
        .VECTOR_FETCH(vf), .BREAK_STATE(brk), .BREAK_CLEAR_ENABLE(bce),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .PULLUP_EN(pull), .FORCE_INPUT(frc), .KEY_IRQ(irq), .WAKE_REQ(wake));

    kbiu_keys keys (.clk(clk), .press(press), .pull_on(pull), .pins(pins));

    // Random source and expected status word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] sc(input logic p, m, s);
        return {28'h0, p, 1'b0, m, s};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic sck(input logic [31:0] e);
        rd(4'h0);
        chk("status", e, got);
    endtask

    task automatic tally_and_finish;
        $display("Mismatches %0d, checks %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog: the tests take a few hundred cycles
    initial begin
        wt(20000);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        wt(6);
        rst_n <= 1'b1;
        sck(sc(0, 0, 0));
        rd(4'h4);
        chk("enable", 32'h0, got);
        chk("rresp", {30'h0, kbiu_pkg::KBIU_RESP_OKAY}, {30'h0, resp});
        rd(4'h8);
        chk("unmapped", 32'h0, got);
        chk("rresp", {30'h0, kbiu_pkg::KBIU_RESP_SLVERR}, {30'h0, resp});
        wr(4'hc, 8'hff);
        chk("bresp", {30'h0, kbiu_pkg::KBIU_RESP_SLVERR}, {30'h0, resp});
        rnd = lfsr(rnd);
        k = int'(rnd[2:0]);
        k2 = (k + 3) % 8;
        // Masked bring-up with one pin left out, false requests dropped
        wr(4'h0, 8'h02);
        chk("bresp", {30'h0, kbiu_pkg::KBIU_RESP_OKAY}, {30'h0, resp});
        wr(4'h4, ~(8'h01 << k));
        wt(5);
        chk("pullup", {24'h0, ~(8'h01 << k)}, {24'h0, pull});
        chk("force", {24'h0, ~(8'h01 << k)}, {24'h0, frc});
        wr(4'h0, 8'h06);
        wr(4'h0, 8'h00);
        press[k] <= 1'b1;
        wt(5);
        sck(sc(0, 0, 0));
        press[k] <= 1'b0;
        wr(4'h4, 8'hff);
        // Edge mode: latch, second fall ignored, ack clears
        press[k2] <= 1'b1;
        wt(5);
        chk("irq", 32'h1, {31'h0, irq});
        chk("wake", 32'h1, {31'h0, wake});
        sck(sc(1, 0, 0));
        press[k] <= 1'b1;
        wr(4'h0, 8'h04);
        wt(5);
        sck(sc(0, 0, 0));
        press <= 8'h00;
        wt(5);
        // Mask hides request, vector fetch clears it
        press[k] <= 1'b1;
        wt(5);
        wr(4'h0, 8'h02);
        wt(1);
        chk("irq", 32'h0, {31'h0, irq});
        sck(sc(1, 1, 0));
        wr(4'h0, 8'h00);
        wt(2);
        vf <= 1'b1;
        wt(1);
        vf <= 1'b0;
        wt(3);
        sck(sc(0, 0, 0));
        press <= 8'h00;
        wr(4'h0, 8'h04);
        press[k2] <= 1'b1;
        wt(5);
        sck(sc(1, 0, 0));
        press <= 8'h00;
        wt(5);
        // Break: ack blocked unless clear enabled, stays cleared after
        brk <= 1'b1;
        wr(4'h0, 8'h04);
        sck(sc(1, 0, 0));
        bce <= 1'b1;
        wr(4'h0, 8'h04);
        sck(sc(0, 0, 0));
        brk <= 1'b0;
        bce <= 1'b0;
        sck(sc(0, 0, 0));
        // Level mode, ack before release and after it
        wr(4'h0, 8'h01);
        press[k] <= 1'b1;
        wt(5);
        wr(4'h0, 8'h05);
        sck(sc(1, 0, 1));
        press <= 8'h00;
        wt(5);
        sck(sc(0, 0, 1));
        press[k2] <= 1'b1;
        wt(5);
        press <= 8'h00;
        wt(5);
        sck(sc(1, 0, 1));
        wr(4'h0, 8'h05);
        sck(sc(0, 0, 1));
        // Clock enable low freezes the latch; it catches up once raised
        ce <= 1'b0;
        press[k] <= 1'b1;
        wt(5);
        chk("irq", 32'h0, {31'h0, irq});
        ce <= 1'b1;
        wt(5);
        chk("irq", 32'h1, {31'h0, irq});
        // Reset while a pin is held low
        press[k] <= 1'b1;
        wt(5);
        rst_n <= 1'b0;
        wt(6);
        rst_n <= 1'b1;
        sck(sc(0, 0, 0));
        chk("irq", 32'h0, {31'h0, irq});
        tally_and_finish();
    end
endmodule
`default_nettype wire
